//--- verification/nbu_remote.sv
// Remote UART model standing on the far end of the serial line
module nbu_remote (
  input wire logic sys_clk, // Clock used for bit timing
  input wire logic lineIn, // Device transmit line
  input wire logic [7:0] bitClks, // Clocks per received bit
  output logic lineOut, // Device receive line
  output logic frameDone, // One cycle per captured frame
  output logic [9:0] frameData // Stop, ninth bit, byte
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] cap;

  // Line idles high until a frame is sent
  initial begin
    lineOut = 1'b1;
    frameDone = 1'b0;
    frameData = 10'h000;
  end

  // Sends start low, nine bits LSB first, stop high
  task automatic send(input logic [8:0] f, input int bc);
    lineOut <= 1'b0;
    repeat (bc) @(posedge sys_clk);
    for (int i = 0; i < 9; i++) begin
      lineOut <= f[i];
      repeat (bc) @(posedge sys_clk);
    end
    lineOut <= 1'b1;
    repeat (bc) @(posedge sys_clk);
  endtask

  // Captures frames mid-bit after a falling start edge
  always begin
    @(negedge lineIn);
    repeat (bitClks / 2) @(posedge sys_clk);
    for (int i = 0; i < 10; i++) begin
      repeat (bitClks) @(posedge sys_clk);
      cap[i] = lineIn;
    end
    frameData <= cap;
    frameDone <= 1'b1;
    @(posedge sys_clk);
    frameDone <= 1'b0;
  end
endmodule

//--- verification/tb.sv
// Self-checking bench for the 9-bit UART
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic t1Overflow, t2Overflow, rxPin, txPin, irq, frameDone;
  logic [7:0] awaddr, araddr, bitClks, ctl;
  logic [31:0] wdata, rdata, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [9:0] frameData;
  logic [65:0] note;
  logic [65:0] readQ[$];
  logic [9:0] frameQ[$];
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int txBcs[6] = '{64, 32, 64, 32, 32, 32};
  int rxBcs[6] = '{64, 32, 64, 32, 32, 64};
  logic [7:0] vars[6] = '{8'h00, 8'h00, 8'h40, 8'h40, 8'h40, 8'h40};
  logic [7:0] pwrs[6] = '{8'h00, 8'h80, 8'h00, 8'h80, 8'h00, 8'h00};
  logic [7:0] t2s[6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h30, 8'h10};

  nbu_uart #(.ADDR_W(8)) u_nbu_uart (.sys_clk(sys_clk), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .t1Overflow(t1Overflow), .t2Overflow(t2Overflow),
    .rxPin(rxPin), .txPin(txPin), .irq(irq));

  nbu_remote u_nbu_remote (.sys_clk(sys_clk), .lineIn(txPin),
    .bitClks(bitClks), .lineOut(rxPin), .frameDone(frameDone),
    .frameData(frameData));

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Bus write: both halves offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    check("bresp", {30'h0, bresp}, {30'h0, er});
  endtask

  // Bus read: notes the expected word, the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m,
                    input logic [1:0] er);
    readQ.push_back({m, er, e});
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
  endtask

  // Monitor of read answers and frames captured by the remote end
  always @(posedge sys_clk) begin
    if (rvalid && rready) begin
      note = readQ.pop_front();
      check("rdata", rdata & note[65:34], note[31:0]);
      check("rresp", {30'h0, rresp}, {30'h0, note[33:32]});
    end
    if (frameDone)
      check("frame", 32'(frameData), 32'(frameQ.pop_front()));
  end

  // Timer overflow pulses every second clock, and the hang limit
  always @(posedge sys_clk) begin
    t1Overflow <= rst ? 1'b0 : ~t1Overflow;
    t2Overflow <= rst ? 1'b0 : ~t2Overflow;
    cycles++;
    if (cycles == 40000) begin
      failures++;
      stop_test();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {awvalid, wvalid, arvalid} = 3'h0;
    {bready, rready} = 2'h3;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    bitClks = 8'h40;
    seed = 32'hCA59;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++)
      rd(8'(i * 4), 32'h0, 32'hFF, 2'h0);
    check("irq", {31'h0, irq}, 32'h0);
    rd(8'h20, 32'h0, 32'hFFFFFFFF, 2'h2);
    wr(8'h20, 32'hFF, 2'h2);
    wr(8'h0C, 32'h3, 2'h0);
    for (int c = 0; c < 6; c++) begin
      seed = lfsr(seed);
      bitClks = 8'(txBcs[c]);
      ctl = vars[c] | 8'h10;
      wr(8'h10, {24'h0, pwrs[c]}, 2'h0);
      wr(8'h14, {24'h0, t2s[c]}, 2'h0);
      wr(8'h00, {24'h0, ctl | {4'h0, ~c[0], 3'h0}}, 2'h0);
      frameQ.push_back({1'b1, c[0], seed[7:0]});
      wr(8'h04, seed, 2'h0);
      wr(8'h00, {24'h0, ctl | {4'h0, c[0], 3'h0}}, 2'h0);
      u_nbu_remote.send({seed[8], seed[23:16]}, rxBcs[c]);
      repeat (2 * txBcs[c]) @(posedge sys_clk);
      check("irq", {31'h0, irq}, 32'h1);
      rd(8'h08, 32'h3, 32'h3, 2'h0);
      rd(8'h04, {24'h0, seed[23:16]}, 32'hFF, 2'h0);
      rd(8'h00, {29'h0, seed[8], 2'h0}, 32'h4, 2'h0);
      wr(8'h0C, 32'h0, 2'h0);
      check("irq", {31'h0, irq}, 32'h0);
      wr(8'h0C, 32'h3, 2'h0);
      wr(8'h08, 32'h3, 2'h0);
      rd(8'h08, 32'h0, 32'h3, 2'h0);
    end
    wr(8'h10, 32'h0, 2'h0);
    wr(8'h14, 32'h0, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    u_nbu_remote.send(9'h1A5, 64);
    rd(8'h08, 32'h0, 32'h1, 2'h0);
    wr(8'h00, 32'h30, 2'h0);
    u_nbu_remote.send(9'h05A, 64);
    rd(8'h08, 32'h0, 32'h1, 2'h0);
    u_nbu_remote.send(9'h13C, 64);
    rd(8'h08, 32'h1, 32'h1, 2'h0);
    // Address frame while the buffer is still full must be dropped
    u_nbu_remote.send(9'h1C3, 64);
    rd(8'h04, 32'h3C, 32'hFF, 2'h0);
    rd(8'h00, 32'h34, 32'h7C, 2'h0);
    check("frames left", frameQ.size(), 32'h0);
    stop_test();
  end
endmodule

//--- verilog/nbu_baud.sv
// Oversampling tick generator for receive and transmit directions
`include "nbu_map.svh"
module nbu_baud (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire nbu_pkg::nbu_rate_cfg_t cfg, // Rate configuration
  input wire logic t1Overflow, // Timer 1 overflow pulse
  input wire logic t2Overflow, // Timer 2 overflow pulse
  output logic [1:0] tick // Oversample enables: [0] receive, [1] transmit
);
  localparam int SLOW = `NBU_FIXED_DIV_SLOW / `NBU_OVERSAMPLE;
  localparam int FAST = `NBU_FIXED_DIV_FAST / `NBU_OVERSAMPLE;
  logic [4:0] fixedCnt;
  logic [4:0] fixedLast;
  logic fixedTick;
  logic t1Phase;
  logic t1Tick;

  // Fixed rate: 16 ticks per bit at clock/64 or clock/32
  assign fixedLast = cfg.doubler ? 5'(FAST - 1) : 5'(SLOW - 1); // see [RULE11]
  assign fixedTick = (fixedCnt >= fixedLast); // Recovers if period shrinks
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fixedCnt <= 5'h00;
    end else if (fixedTick) begin
      fixedCnt <= 5'h00;
    end else begin
      fixedCnt <= fixedCnt + 5'h01;
    end
  end

  // Timer 1 overflow halved unless doubled: bit rate overflow/32 or /16
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      t1Phase <= 1'b0;
    end else if (t1Overflow) begin
      t1Phase <= ~t1Phase;
    end
  end
  assign t1Tick = t1Overflow && (cfg.doubler || t1Phase); // see [RULE15]

  // Per-direction source choice; Timer 2 gives overflow/16
  for (genvar d = 0; d < 2; d++) begin : g_dir
    logic fromT2;
    assign fromT2 = (d == 1) ? cfg.txFromT2 : cfg.rxFromT2; // see [RULE16]
    assign tick[d] = cfg.variableRate ?
      (fromT2 ? t2Overflow : t1Tick) : fixedTick; // see [RULE14]
  end
endmodule

//--- verilog/nbu_map.svh
// Register map, field positions and timing counts of the 9-bit UART
// Operation
// [RULE1] Frame: start, eight data bits LSB first, ninth bit, stop.
// [RULE2] Transmitted ninth bit is the current tx_ninth_bit control value.
// [RULE3] Received ninth bit goes to rx_ninth_bit; stop bit not checked.
// [RULE4] Writing serial_buffer starts a frame carrying that byte.
// [RULE5] tx_done_flag sets at start of the stop bit.
// [RULE6] Frames are accepted only while receive enable is one.
// [RULE7] Load only if rx_done_flag is 0 and, when filtering, ninth is 1.
// [RULE8] Load writes byte, ninth bit, and sets rx_done_flag.
// [RULE9] Failed load leaves buffer, ninth bit and flag unchanged.
// [RULE10] Interrupt requested, if enabled, when either done flag sets.
// [RULE11] Fixed rate is clock/64, or clock/32 with baud_doubler set.
// [RULE12] baud_doubler resets to zero, selecting the slower rate.
// [RULE13] Variable-rate mode keeps frame, flags and load conditions.
// [RULE14] Variable rate comes from Timer 1 or Timer 2 overflow pulses.
// [RULE15] Timer 1: overflow/32, or /16 doubled; Timer 2: overflow/16.
// [RULE16] Receive and transmit rate sources are selected separately.
// [RULE17] Line idles high; start low, stop high; start on falling edge.
`ifndef NBU_MAP_SVH
`define NBU_MAP_SVH
`define NBU_OFS_CTRL 8'h00
`define NBU_OFS_BUF 8'h04
`define NBU_OFS_STAT 8'h08
`define NBU_OFS_MASK 8'h0C
`define NBU_OFS_PWR 8'h10
`define NBU_OFS_T2 8'h14
`define NBU_CTRL_RX9 2
`define NBU_CTRL_TX9 3
`define NBU_CTRL_RXEN 4
`define NBU_CTRL_FILTER 5
`define NBU_CTRL_VAR 6
`define NBU_STAT_RXDONE 0
`define NBU_STAT_TXDONE 1
`define NBU_PWR_DOUBLER 7
`define NBU_T2_TXSEL 4
`define NBU_T2_RXSEL 5
`define NBU_RST_BYTE 8'h00
`define NBU_RST_FLAGS 2'h0
`define NBU_OVERSAMPLE 16
`define NBU_FIXED_DIV_SLOW 64
`define NBU_FIXED_DIV_FAST 32
`define NBU_SAMPLE_MID 4'h7
`define NBU_SAMPLE_LAST 4'hF
`define NBU_LAST_DATA 4'h8
`define NBU_NINTH_IDX 4'h9
`define NBU_STOP_IDX 4'hA
`define NBU_RESP_OKAY 2'h0
`define NBU_RESP_SLVERR 2'h2
`endif

//--- verilog/nbu_pkg.sv
// Types shared by the 9-bit UART modules
package nbu_pkg;
  // Rate configuration handed to the tick generator
  typedef struct packed {
    logic variableRate;
    logic doubler;
    logic rxFromT2;
    logic txFromT2;
  } nbu_rate_cfg_t;

  // Receiver states, one-hot
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_BITS = 4'h4,
    RX_STOP = 4'h8
  } nbu_rx_state_t;
endpackage

//--- verilog/nbu_tx.sv
// Transmit shifter for the 11-bit frame
`include "nbu_map.svh"
module nbu_tx (
  input wire logic sys_clk, // System clock
  input wire logic rst, // Asynchronous reset, active high
  input wire logic tick, // Oversample enable, 16 per bit
  input wire logic start, // Load pulse from buffer write
  input wire logic [7:0] data, // Byte to send
  input wire logic ninth, // Live ninth-bit control value
  output logic txLine, // Serial line out
  output logic busy, // Frame in progress
  output logic donePulse // One cycle at start of stop bit
);
  logic [7:0] shift;
  logic [3:0] cnt;
  logic [3:0] bitIdx;
  logic bitEnd;

  assign bitEnd = busy && tick && (cnt == `NBU_SAMPLE_LAST);

  // Frame sequencing: start low, data LSB first, ninth, stop high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      txLine <= 1'b1;
      shift <= `NBU_RST_BYTE;
      cnt <= 4'h0;
      bitIdx <= 4'h0;
      donePulse <= 1'b0;
    end else begin
      donePulse <= 1'b0;
      if (start && !busy) begin
        busy <= 1'b1; // see [RULE4]
        txLine <= 1'b0; // see [RULE17]
        shift <= data;
        cnt <= 4'h0;
        bitIdx <= 4'h0;
      end else if (busy && tick) begin
        cnt <= cnt + 4'h1;
        if (bitEnd) begin
          bitIdx <= bitIdx + 4'h1;
          if (bitIdx < `NBU_LAST_DATA) begin
            txLine <= shift[0]; // see [RULE1]
            shift <= {1'b0, shift[7:1]};
          end else if (bitIdx == `NBU_LAST_DATA) begin
            txLine <= ninth; // see [RULE2]
          end else if (bitIdx == `NBU_NINTH_IDX) begin
            txLine <= 1'b1;
            donePulse <= 1'b1; // see [RULE5]
          end else begin
            busy <= 1'b0;
          end
        end
      end
    end
  end

  a_tx_ninth_bit: assert property (@(posedge sys_clk) disable iff (rst)
    bitEnd && bitIdx == `NBU_LAST_DATA |=> txLine == $past(ninth)) // [RULE2]
    else $error("ninth bit not taken from control value");
  a_tx_done_stop: assert property (@(posedge sys_clk) disable iff (rst)
    donePulse |-> txLine && busy && bitIdx == `NBU_STOP_IDX) // [RULE5]
    else $error("done flag not at start of stop bit");
  a_tx_idle_high: assert property (@(posedge sys_clk) disable iff (rst)
    !busy |-> txLine) // [RULE17]
    else $error("line not high while idle");
endmodule

//--- verilog/nbu_uart.sv
// 9-bit UART with AXI4-Lite registers, receiver and interrupt logic
`include "nbu_map.svh"
module nbu_uart #(
  parameter int ADDR_W = 8 // AXI address width
) (
  input wire logic sys_clk, // System clock, 200 MHz
  input wire logic rst, // Asynchronous reset, active high
  input wire logic [ADDR_W-1:0] awaddr, // Write address
  input wire logic awvalid, // Write address valid
  output logic awready, // Write address ready
  input wire logic [31:0] wdata, // Write data
  input wire logic [3:0] wstrb, // Write byte strobes
  input wire logic wvalid, // Write data valid
  output logic wready, // Write data ready
  output logic [1:0] bresp, // Write response
  output logic bvalid, // Write response valid
  input wire logic bready, // Write response ready
  input wire logic [ADDR_W-1:0] araddr, // Read address
  input wire logic arvalid, // Read address valid
  output logic arready, // Read address ready
  output logic [31:0] rdata, // Read data
  output logic [1:0] rresp, // Read response
  output logic rvalid, // Read data valid
  input wire logic rready, // Read data ready
  input wire logic t1Overflow, // Timer 1 overflow pulse
  input wire logic t2Overflow, // Timer 2 overflow pulse
  input wire logic rxPin, // Serial line in
  output logic txPin, // Serial line out
  output logic irq // Serial interrupt, level
);
  // Write channel holding registers
  logic awHeld;
  logic wHeld;
  logic [ADDR_W-1:0] wrAddr;
  logic [7:0] wrByte;
  logic wrLane;
  logic wrDo;
  logic wrMapped;
  logic rdMapped;
  // Register contents
  logic multiprocFilter;
  logic rxEnable;
  logic txNinthBit;
  logic rxNinthBit;
  logic variableRate;
  logic baudDoubler;
  logic rxRateSelect;
  logic txRateSelect;
  logic [7:0] serialBuffer;
  logic [1:0] status;
  logic [1:0] mask;
  logic [1:0] statusSet;
  logic [1:0] statusClr;
  // Datapath
  nbu_pkg::nbu_rate_cfg_t rateCfg;
  logic [1:0] tick;
  logic txStart;
  logic txBusy;
  logic txDone;
  logic rxSync1;
  logic rxSync2;
  logic rxSync3;
  logic rxLine;
  logic rxPrev;
  nbu_pkg::nbu_rx_state_t rxState;
  logic [3:0] rxCnt;
  logic [3:0] rxBitIdx;
  logic [8:0] rxShift;
  logic rxFrameEnd;
  logic rxLoad;

  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    logic [7:0] o;
    o = a[7:0];
    isMapped = (o == `NBU_OFS_CTRL) || (o == `NBU_OFS_BUF) ||
      (o == `NBU_OFS_STAT) || (o == `NBU_OFS_MASK) ||
      (o == `NBU_OFS_PWR) || (o == `NBU_OFS_T2);
  endfunction

  // Address and data are taken independently, in either order
  assign awready = !awHeld && !bvalid;
  assign wready = !wHeld && !bvalid;
  assign wrDo = awHeld && wHeld && !bvalid;
  assign wrMapped = isMapped(wrAddr);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wrAddr <= '0;
      wrByte <= `NBU_RST_BYTE;
      wrLane <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awHeld <= 1'b1;
        wrAddr <= awaddr;
      end else if (wrDo) begin
        awHeld <= 1'b0;
      end
      if (wvalid && wready) begin
        wHeld <= 1'b1;
        wrByte <= wdata[7:0];
        wrLane <= wstrb[0];
      end else if (wrDo) begin
        wHeld <= 1'b0;
      end
    end
  end

  // Write response follows both halves by one cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= `NBU_RESP_OKAY;
    end else if (wrDo) begin
      bvalid <= 1'b1;
      bresp <= wrMapped ? `NBU_RESP_OKAY : `NBU_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control, power and rate-select registers, low byte lane only
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      multiprocFilter <= 1'b0;
      rxEnable <= 1'b0;
      txNinthBit <= 1'b0;
      variableRate <= 1'b0;
      baudDoubler <= 1'b0; // see [RULE12]
      rxRateSelect <= 1'b0;
      txRateSelect <= 1'b0;
      mask <= `NBU_RST_FLAGS;
    end else if (wrDo && wrLane) begin
      unique case (wrAddr[7:0])
        `NBU_OFS_CTRL: begin
          multiprocFilter <= wrByte[`NBU_CTRL_FILTER];
          rxEnable <= wrByte[`NBU_CTRL_RXEN]; // see [RULE6]
          txNinthBit <= wrByte[`NBU_CTRL_TX9];
          variableRate <= wrByte[`NBU_CTRL_VAR]; // see [RULE13]
        end
        `NBU_OFS_PWR: baudDoubler <= wrByte[`NBU_PWR_DOUBLER];
        `NBU_OFS_T2: begin
          rxRateSelect <= wrByte[`NBU_T2_RXSEL]; // see [RULE16]
          txRateSelect <= wrByte[`NBU_T2_TXSEL];
        end
        `NBU_OFS_MASK: mask <= wrByte[1:0];
        default: ;
      endcase
    end
  end

  // Read channel: data registered, unmapped answers SLVERR
  assign arready = !rvalid;
  assign rdMapped = isMapped(araddr);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `NBU_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= rdMapped ? `NBU_RESP_OKAY : `NBU_RESP_SLVERR;
      rdata <= 32'h0000_0000;
      unique case (araddr[7:0])
        `NBU_OFS_CTRL: begin
          rdata[`NBU_CTRL_FILTER] <= multiprocFilter;
          rdata[`NBU_CTRL_RXEN] <= rxEnable;
          rdata[`NBU_CTRL_TX9] <= txNinthBit;
          rdata[`NBU_CTRL_RX9] <= rxNinthBit;
          rdata[`NBU_CTRL_VAR] <= variableRate;
        end
        `NBU_OFS_BUF: rdata[7:0] <= serialBuffer;
        `NBU_OFS_STAT: rdata[1:0] <= status;
        `NBU_OFS_MASK: rdata[1:0] <= mask;
        `NBU_OFS_PWR: rdata[`NBU_PWR_DOUBLER] <= baudDoubler;
        `NBU_OFS_T2: begin
          rdata[`NBU_T2_RXSEL] <= rxRateSelect;
          rdata[`NBU_T2_TXSEL] <= txRateSelect;
        end
        default: ;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // Tick generation per direction
  assign rateCfg = '{variableRate: variableRate, doubler: baudDoubler,
    rxFromT2: rxRateSelect, txFromT2: txRateSelect};
  nbu_baud u_baud (
    .sys_clk(sys_clk),
    .rst(rst),
    .cfg(rateCfg),
    .t1Overflow(t1Overflow),
    .t2Overflow(t2Overflow),
    .tick(tick)
  );

  // Buffer write launches a frame; ignored while one is under way
  assign txStart = wrDo && wrLane &&
    (wrAddr[7:0] == `NBU_OFS_BUF); // see [RULE4]
  nbu_tx u_tx (
    .sys_clk(sys_clk),
    .rst(rst),
    .tick(tick[1]),
    .start(txStart),
    .data(wrByte),
    .ninth(txNinthBit),
    .txLine(txPin),
    .busy(txBusy),
    .donePulse(txDone)
  );

  // Line synchroniser; a change counts once stages two and three agree
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxSync1 <= 1'b1;
      rxSync2 <= 1'b1;
      rxSync3 <= 1'b1;
      rxLine <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      rxSync1 <= rxPin;
      rxSync2 <= rxSync1;
      rxSync3 <= rxSync2;
      if (rxSync2 == rxSync3) begin
        rxLine <= rxSync3;
      end
      rxPrev <= rxLine;
    end
  end

  // Receiver: detect start, sample mid-bit, shift nine bits, skip stop
  assign rxFrameEnd = (rxState == nbu_pkg::RX_STOP) && tick[0] &&
    (rxCnt == `NBU_SAMPLE_LAST);
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rxState <= nbu_pkg::RX_IDLE;
      rxCnt <= 4'h0;
      rxBitIdx <= 4'h0;
      rxShift <= 9'h000;
    end else begin
      unique case (rxState)
        nbu_pkg::RX_IDLE: begin
          if (rxEnable && rxPrev && !rxLine) begin // see [RULE6] [RULE17]
            rxState <= nbu_pkg::RX_START;
            rxCnt <= 4'h0;
          end
        end
        nbu_pkg::RX_START: begin
          if (tick[0]) begin
            rxCnt <= rxCnt + 4'h1;
            if (rxCnt == `NBU_SAMPLE_MID) begin
              rxCnt <= 4'h0;
              rxBitIdx <= 4'h0;
              rxState <= rxLine ? nbu_pkg::RX_IDLE : nbu_pkg::RX_BITS;
            end
          end
        end
        nbu_pkg::RX_BITS: begin
          if (tick[0]) begin
            rxCnt <= rxCnt + 4'h1;
            if (rxCnt == `NBU_SAMPLE_LAST) begin
              rxShift <= {rxLine, rxShift[8:1]}; // see [RULE1]
              rxBitIdx <= rxBitIdx + 4'h1;
              if (rxBitIdx == `NBU_LAST_DATA) begin
                rxState <= nbu_pkg::RX_STOP;
              end
            end
          end
        end
        nbu_pkg::RX_STOP: begin
          if (tick[0]) begin
            rxCnt <= rxCnt + 4'h1;
            if (rxFrameEnd) begin
              rxState <= nbu_pkg::RX_IDLE; // see [RULE3]
            end
          end
        end
        default: rxState <= nbu_pkg::RX_IDLE;
      endcase
    end
  end

  // Load only into an empty buffer, and only addresses when filtering
  assign rxLoad = rxFrameEnd && !status[`NBU_STAT_RXDONE] &&
    (!multiprocFilter || rxShift[8]); // see [RULE7]
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      serialBuffer <= `NBU_RST_BYTE;
      rxNinthBit <= 1'b0;
    end else if (rxLoad) begin
      serialBuffer <= rxShift[7:0]; // see [RULE8] [RULE9]
      rxNinthBit <= rxShift[8]; // see [RULE3]
    end
  end

  // Done flags: hardware set wins over a write-one clear
  assign statusSet = {txDone, rxLoad};
  assign statusClr = (wrDo && wrLane && wrAddr[7:0] == `NBU_OFS_STAT) ?
    wrByte[1:0] : 2'h0;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= `NBU_RST_FLAGS;
    end else begin
      status <= (status & ~statusClr) | statusSet; // see [RULE5] [RULE8]
    end
  end
  assign irq = |(status & mask); // see [RULE10]

  a_load_sets_done: assert property (@(posedge sys_clk) disable iff (rst)
    rxLoad |=> status[`NBU_STAT_RXDONE] &&
      serialBuffer == $past(rxShift[7:0]) &&
      rxNinthBit == $past(rxShift[8])) // [RULE8]
    else $error("accepted frame not loaded");
  a_load_needs_empty: assert property (@(posedge sys_clk) disable iff (rst)
    rxLoad |-> !status[`NBU_STAT_RXDONE] &&
      (!multiprocFilter || rxShift[8])) // [RULE7]
    else $error("frame loaded against the load conditions");
  a_discard_holds: assert property (@(posedge sys_clk) disable iff (rst)
    rxFrameEnd && !rxLoad |=> $stable(serialBuffer) &&
      $stable(rxNinthBit)) // [RULE9]
    else $error("discarded frame changed the buffer");
  a_frame_ends_idle: assert property (@(posedge sys_clk) disable iff (rst)
    rxFrameEnd |=> rxState == nbu_pkg::RX_IDLE) // [RULE3]
    else $error("receiver did not finish at stop bit");
  a_rx_enable_gate: assert property (@(posedge sys_clk) disable iff (rst)
    rxState == nbu_pkg::RX_IDLE ##1 rxState == nbu_pkg::RX_START
      |-> $past(rxEnable)) // [RULE6]
    else $error("frame started while receiver disabled");
  a_irq_on_flag: assert property (@(posedge sys_clk) disable iff (rst)
    (rxLoad && mask[`NBU_STAT_RXDONE]) ||
      (txDone && mask[`NBU_STAT_TXDONE]) |=> irq) // [RULE10]
    else $error("enabled done flag raised no interrupt");
  a_tx_starts_now: assert property (@(posedge sys_clk) disable iff (rst)
    txStart && !txBusy |=> txBusy && !txPin) // [RULE4]
    else $error("buffer write did not start a frame");
  a_fixed_slow_rate: assert property (@(posedge sys_clk) disable iff (rst)
    !variableRate && !baudDoubler && tick[1] ##1
      (!variableRate && !baudDoubler)[*4]
      |-> tick[1] && !$past(tick[1]) && !$past(tick[1], 2) &&
        !$past(tick[1], 3)) // [RULE11]
    else $error("fixed slow tick spacing wrong");
  a_fixed_fast_rate: assert property (@(posedge sys_clk) disable iff (rst)
    !variableRate && baudDoubler && tick[0] ##1
      (!variableRate && baudDoubler)[*2]
      |-> tick[0] && !$past(tick[0])) // [RULE11]
    else $error("fixed fast tick spacing wrong");
  a_doubler_reset: assert property (@(posedge sys_clk)
    $fell(rst) |-> !baudDoubler) // [RULE12]
    else $error("baud doubler not clear after reset");
  a_t2_rate_source: assert property (@(posedge sys_clk) disable iff (rst)
    variableRate && rxRateSelect |-> tick[0] == t2Overflow) // [RULE16]
    else $error("receive rate not from Timer 2");
  a_t1_halved: assert property (@(posedge sys_clk) disable iff (rst)
    variableRate && !baudDoubler && !txRateSelect && tick[1] ##1
      !t1Overflow ##1 t1Overflow && variableRate && !baudDoubler &&
      !txRateSelect |-> !tick[1]) // [RULE15]
    else $error("Timer 1 overflow not halved");
endmodule
